// ---- hw/iocc_top.sv ----
`timescale 1ns/10ps
module iocc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rc_osc_slow_enable,
  input wire logic rc_osc_mid_enable,
  input wire logic ring32m_enable,
  input wire logic en_write,
  input wire logic slow_tick_in,
  input wire logic mid_tick_in,
  input wire logic fast_tick_in,
  input wire logic ext_ready_in,
  input wire logic pll_ready_in,
  input wire logic [7:0] cal_wdata,
  input wire logic cal_write,
  input wire logic [2:0] sys_sel_req,
  input wire logic sys_sel_write,
  input wire logic [1:0] pll_src_req,
  input wire logic pll_src_write,
  input wire logic rtc_use_slow,
  input wire logic autocal_use_slow,
  input wire logic ulp_demand,
  output logic rc_osc_slow_en_q,
  output logic rc_osc_mid_en_q,
  output logic ring32m_en_q,
  output logic rc_osc_slow_ready,
  output logic rc_osc_mid_ready,
  output logic ring32m_ready,
  output logic [7:0] slow_rc_calibration,
  output logic [7:0] mid_rc_calibration,
  output logic [7:0] fast_ring_calibration,
  output logic [2:0] sys_sel,
  output logic sys_sel_refused,
  output logic [1:0] pll_src,
  output logic fast_pll_tick,
  output logic rtc_tick,
  output logic autocal_ref_tick,
  output logic ultra_low_power_osc_enable
);
  // pin-sourced inputs: two-flop synchronisers
  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] s3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
    end else begin
      s1 <= {pll_ready_in, ext_ready_in, fast_tick_in, mid_tick_in, slow_tick_in};
      s2 <= s1;
      s3 <= s2;
    end
  end
  // edge of synchronised oscillator levels counts as one tick
  logic [2:0] tick;
  assign tick = s2[2:0] & ~s3[2:0];

  logic [2:0] en;
  logic [2:0] next_en;
  logic [7:0] cal_slow;
  logic [7:0] next_cal_slow;
  iocc_pkg::iocc_sys_t sel;
  iocc_pkg::iocc_sys_t next_sel;
  iocc_pkg::iocc_pll_t psrc;
  iocc_pkg::iocc_pll_t next_psrc;
  logic refused;
  logic next_refused;
  logic [1:0] fdiv;
  logic [1:0] next_fdiv;
  logic fpll;
  logic next_fpll;
  logic aref;
  logic next_aref;
  logic ulp;
  logic next_ulp;
  logic [2:0] rdy;
  logic rtc_pulse;
  logic src_ok;

  iocc_osc_if osc_if [3] ();
  // one ready timer per software-enabled oscillator
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_osc
      assign osc_if[g].enable = en[g];
      assign osc_if[g].osc_tick = tick[g];
      assign rdy[g] = osc_if[g].ready;
      iocc_ready_timer #(.STARTUP(iocc_pkg::IOCC_STARTUP_CYCLES)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .port_osc(osc_if[g])
      );
    end
  endgenerate

  // rtc sees slow rc only after the divide to 1.024 kHz
  iocc_rtc_div #(.DIV(iocc_pkg::IOCC_RTC_DIV)) u_rtc_div (
    .clk(clk),
    .rst_n(rst_n),
    .in_tick(tick[0] & rdy[0] & rtc_use_slow),
    .out_tick(rtc_pulse)
  );

  // readiness of a requested system clock; ulp has no code here
  always_comb begin
    unique case (iocc_pkg::iocc_sys_t'(sys_sel_req))
      iocc_pkg::IOCC_SYS_MID: src_ok = rdy[1];
      iocc_pkg::IOCC_SYS_SLOW: src_ok = rdy[0];
      iocc_pkg::IOCC_SYS_FAST: src_ok = rdy[2];
      iocc_pkg::IOCC_SYS_EXT: src_ok = s2[3];
      iocc_pkg::IOCC_SYS_PLL: src_ok = s2[4];
      default: src_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_en = en;
    next_cal_slow = cal_slow;
    next_sel = sel;
    next_psrc = psrc;
    next_refused = 1'b0;
    // independent enables, no exclusion between sources
    if (en_write) begin
      next_en = {ring32m_enable, rc_osc_mid_enable, rc_osc_slow_enable};
    end
    if (cal_write) begin
      next_cal_slow = cal_wdata;
    end
    if (sys_sel_write) begin
      if (src_ok) begin
        next_sel = iocc_pkg::iocc_sys_t'(sys_sel_req);
      end else begin
        next_refused = 1'b1;
      end
    end
    // slow rc has no pll code, so it can never be chosen
    if (pll_src_write && pll_src_req != 2'h3) begin
      next_psrc = iocc_pkg::iocc_pll_t'(pll_src_req);
    end
  end

  // fast ring to pll: one pulse per four fast ticks
  always_comb begin
    next_fdiv = fdiv;
    next_fpll = 1'b0;
    if (tick[2] && rdy[2]) begin
      next_fdiv = fdiv + 2'h1;
      next_fpll = (fdiv == 2'(iocc_pkg::IOCC_FAST_PLL_DIV - 1));
    end
    next_aref = tick[0] & rdy[0] & autocal_use_slow;
    // ulp runs whenever a consumer asks, without any software bit
    next_ulp = ulp_demand;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= iocc_pkg::IOCC_EN_RESET;
      cal_slow <= iocc_pkg::IOCC_CAL_SLOW_RESET;
      sel <= iocc_pkg::IOCC_SYS_MID;
      psrc <= iocc_pkg::IOCC_PLL_MID;
      refused <= 1'b0;
      fdiv <= 2'h0;
      fpll <= 1'b0;
      aref <= 1'b0;
      ulp <= 1'b0;
    end else begin
      en <= next_en;
      cal_slow <= next_cal_slow;
      sel <= next_sel;
      psrc <= next_psrc;
      refused <= next_refused;
      fdiv <= next_fdiv;
      fpll <= next_fpll;
      aref <= next_aref;
      ulp <= next_ulp;
    end
  end

  // registered copies so the ready and rtc_tick outputs come from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_osc_slow_ready <= 1'b0;
      rc_osc_mid_ready <= 1'b0;
      ring32m_ready <= 1'b0;
      rtc_tick <= 1'b0;
    end else begin
      rc_osc_slow_ready <= rdy[0] & en[0];
      rc_osc_mid_ready <= rdy[1] & en[1];
      ring32m_ready <= rdy[2] & en[2];
      rtc_tick <= rtc_pulse;
    end
  end

  assign rc_osc_slow_en_q = en[0];
  assign rc_osc_mid_en_q = en[1];
  assign ring32m_en_q = en[2];
  assign slow_rc_calibration = cal_slow;
  // factory values held after reset; auto-calibration lies outside
  assign mid_rc_calibration = iocc_pkg::IOCC_CAL_MID_RESET;
  assign fast_ring_calibration = iocc_pkg::IOCC_CAL_FAST_RESET;
  assign sys_sel = sel;
  assign sys_sel_refused = refused;
  assign pll_src = psrc;
  assign fast_pll_tick = fpll;
  assign autocal_ref_tick = aref;
  assign ultra_low_power_osc_enable = ulp;
endmodule : iocc_top

// ---- hw/iocc_pkg.sv ----
package iocc_pkg;
  typedef enum logic [2:0] {
    IOCC_SYS_MID,
    IOCC_SYS_SLOW,
    IOCC_SYS_FAST,
    IOCC_SYS_EXT,
    IOCC_SYS_PLL
  } iocc_sys_t;
  typedef enum logic [1:0] {
    IOCC_PLL_MID,
    IOCC_PLL_FAST_DIV4,
    IOCC_PLL_EXT
  } iocc_pll_t;
  localparam logic [2:0] IOCC_EN_RESET = 3'h2;
  localparam int IOCC_STARTUP_CYCLES = 16;
  localparam int IOCC_CAL_W = 8;
  localparam logic [7:0] IOCC_CAL_SLOW_RESET = 8'h80;
  localparam logic [7:0] IOCC_CAL_MID_RESET = 8'h80;
  localparam logic [7:0] IOCC_CAL_FAST_RESET = 8'h80;
  localparam int IOCC_RTC_DIV = 32;
  localparam int IOCC_FAST_PLL_DIV = 4;
endpackage : iocc_pkg

// ---- hw/iocc_osc_if.sv ----
`timescale 1ns/10ps
interface iocc_osc_if;
  logic enable;
  logic osc_tick;
  logic ready;
  modport ctrl (output enable, input ready);
  modport osc (input enable, input osc_tick, output ready);
endinterface : iocc_osc_if

// ---- hw/iocc_ready_timer.sv ----
`timescale 1ns/10ps
module iocc_ready_timer #(
  parameter int STARTUP = iocc_pkg::IOCC_STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  iocc_osc_if.osc port_osc
);
  localparam int CW = $clog2(STARTUP + 1);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic ready_q;
  logic next_ready;
  initial begin
    if (STARTUP < 1) $error("startup must be at least one tick");
  end
  // ready only after STARTUP oscillator ticks with enable held
  always_comb begin
    next_count = count;
    next_ready = ready_q;
    if (!port_osc.enable) begin
      next_count = '0;
      next_ready = 1'b0;
    end else if (!ready_q && port_osc.osc_tick) begin
      if (count == CW'(STARTUP - 1)) begin
        next_ready = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      ready_q <= 1'b0;
    end else begin
      count <= next_count;
      ready_q <= next_ready;
    end
  end
  assign port_osc.ready = ready_q;
endmodule : iocc_ready_timer

// ---- hw/iocc_rtc_div.sv ----
`timescale 1ns/10ps
module iocc_rtc_div #(
  parameter int DIV = iocc_pkg::IOCC_RTC_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_tick,
  output logic out_tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic pulse;
  logic next_pulse;
  initial begin
    if (DIV < 2) $error("divider must be at least two");
  end
  always_comb begin
    next_count = count;
    next_pulse = 1'b0;
    if (in_tick) begin
      if (count == CW'(DIV - 1)) begin
        next_count = '0;
        next_pulse = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end
  assign out_tick = pulse;
endmodule : iocc_rtc_div

// ---- bench/iocc_top_asserts.sv ----
`timescale 1ns/10ps
module iocc_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en_write,
  input wire logic ring32m_enable,
  input wire logic ring32m_en_q,
  input wire logic ring32m_ready,
  input wire logic [7:0] cal_wdata,
  input wire logic cal_write,
  input wire logic [7:0] slow_rc_calibration,
  input wire logic [7:0] mid_rc_calibration,
  input wire logic [2:0] sys_sel_req,
  input wire logic sys_sel_write,
  input wire logic [2:0] sys_sel,
  input wire logic sys_sel_refused,
  input wire logic [1:0] pll_src_req,
  input wire logic pll_src_write,
  input wire logic [1:0] pll_src,
  input wire logic ulp_demand,
  input wire logic ultra_low_power_osc_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence refuse_seq;
    sys_sel_refused ##1 !sys_sel_refused;
  endsequence
  refuse_fast_a:
  assert property (sys_sel_write && sys_sel_req == 3'h2 && !ring32m_ready ##1 !sys_sel_write
    |-> $stable(sys_sel) ##0 refuse_seq) else $error("switch to unready fast ring taken");
  refuse_code_a:
  assert property (sys_sel_write && sys_sel_req > 3'h4 |=> sys_sel_refused && sys_sel <= 3'h4)
    else $error("illegal clock code taken");
  enable_word_a:
  assert property (en_write |=> ring32m_en_q == $past(ring32m_enable))
    else $error("fast ring enable not written");
  ready_drop_a:
  assert property (!ring32m_en_q [*3] |-> !ring32m_ready) else $error("ready while disabled");
  cal_write_a:
  assert property (cal_write |=> slow_rc_calibration == $past(cal_wdata))
    else $error("calibration write lost");
  cal_fixed_a:
  assert property (mid_rc_calibration == iocc_pkg::IOCC_CAL_MID_RESET)
    else $error("mid calibration changed");
  ulp_demand_a:
  assert property (ulp_demand |=> ultra_low_power_osc_enable) else $error("ulp not enabled");
  pll_keep_a:
  assert property (pll_src_write && pll_src_req == 2'h3 |=> $stable(pll_src))
    else $error("reserved pll source taken");
endmodule : iocc_top_asserts

bind iocc_top iocc_top_asserts i_chk (.clk, .rst_n, .en_write, .ring32m_enable, .ring32m_en_q,
  .ring32m_ready, .cal_wdata, .cal_write, .slow_rc_calibration, .mid_rc_calibration,
  .sys_sel_req, .sys_sel_write, .sys_sel, .sys_sel_refused, .pll_src_req, .pll_src_write,
  .pll_src, .ulp_demand, .ultra_low_power_osc_enable);

// ---- bench/iocc_top_tb.sv ----
`timescale 1ns/10ps
module iocc_top_tb;
  logic clk, rst_n, en_write, cal_write, sys_sel_write, pll_src_write;
  logic rtc_use, acal_use, ulp, ext_rdy, pll_rdy, refused, pll_tick, rtc_tick, acal_tick, ulp_en;
  logic [2:0] en, en_q, rdy, sys_sel_req, sys_sel;
  logic [7:0] cal_wdata, slow_cal, mid_cal, fast_cal, d;
  logic [1:0] pll_src_req, pll_src;
  logic [3:0] cyc;
  logic u;
  integer seed = 32'h0000_1dfe, error_cnt = 0, tests_run = 0, i, n0, n1, n2;
  iocc_top i_dut (.clk, .rst_n, .rc_osc_slow_enable(en[0]), .rc_osc_mid_enable(en[1]),
    .ring32m_enable(en[2]), .en_write, .slow_tick_in(cyc[1]), .mid_tick_in(cyc[1]),
    .fast_tick_in(cyc[1]), .ext_ready_in(ext_rdy), .pll_ready_in(pll_rdy), .cal_wdata,
    .cal_write, .sys_sel_req, .sys_sel_write, .pll_src_req, .pll_src_write,
    .rtc_use_slow(rtc_use), .autocal_use_slow(acal_use), .ulp_demand(ulp),
    .rc_osc_slow_en_q(en_q[0]), .rc_osc_mid_en_q(en_q[1]), .ring32m_en_q(en_q[2]),
    .rc_osc_slow_ready(rdy[0]), .rc_osc_mid_ready(rdy[1]), .ring32m_ready(rdy[2]),
    .slow_rc_calibration(slow_cal), .mid_rc_calibration(mid_cal),
    .fast_ring_calibration(fast_cal), .sys_sel, .sys_sel_refused(refused), .pll_src,
    .fast_pll_tick(pll_tick), .rtc_tick, .autocal_ref_tick(acal_tick),
    .ultra_low_power_osc_enable(ulp_en));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // oscillator pins toggle every 2 cycles, so each tick spans 4 cycles
  always @(posedge clk) begin
    cyc <= cyc + 4'h1;
    ulp <= 1'($random(seed));
  end
  function automatic logic [2:0] exp_sel(input logic [2:0] c);
    return (c > 3'h4) ? 3'h0 : c;
  endfunction : exp_sel
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // k picks the strobe: 0 enables, 1 calibration, 2 clock select, 3 pll source
  task pulse(input int k, input logic [7:0] v);
    @(posedge clk);
    {en, cal_wdata, sys_sel_req, pll_src_req} <= {v[2:0], v, v[2:0], v[1:0]};
    {en_write, cal_write, sys_sel_write, pll_src_write} <= {k == 0, k == 1, k == 2, k == 3};
    @(posedge clk);
    {en_write, cal_write, sys_sel_write, pll_src_write} <= 4'h0;
    #1;
  endtask : pulse
  task sel(input logic [2:0] c, input logic [2:0] e, input logic r);
    pulse(2, {5'h00, c});
    chk({5'h00, sys_sel}, {5'h00, e});
    chk({7'h00, refused}, {7'h00, r});
  endtask : sel
  task count(input int n);
    {n0, n1, n2} = {32'h0, 32'h0, 32'h0};
    repeat (n) begin
      u = ulp;
      @(posedge clk);
      #1;
      chk({7'h00, ulp_en}, {7'h00, u});
      {n0, n1, n2} = {n0 + rtc_tick, n1 + pll_tick, n2 + acal_tick};
    end
  endtask : count
  initial begin
    {rst_n, en_write, cal_write, sys_sel_write, pll_src_write} = 5'h00;
    {en, cal_wdata, sys_sel_req, pll_src_req, cyc} = 20'h0_0000;
    {rtc_use, acal_use, ulp, ext_rdy, pll_rdy} = 5'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({5'h00, en_q}, 8'h02);
    chk({5'h00, sys_sel}, 8'h00);
    chk(slow_cal, iocc_pkg::IOCC_CAL_SLOW_RESET);
    chk(fast_cal, iocc_pkg::IOCC_CAL_FAST_RESET);
    chk(mid_cal, iocc_pkg::IOCC_CAL_MID_RESET);
    sel(3'h2, 3'h0, 1'b1);
    sel(3'h1, 3'h0, 1'b1);
    pulse(0, 8'h07);
    chk({5'h00, en_q}, 8'h07);
    for (i = 0; i < 400 && rdy !== 3'h7; i++) @(posedge clk);
    #1;
    chk({5'h00, rdy}, 8'h07);
    @(posedge clk);
    {ext_rdy, pll_rdy, rtc_use, acal_use} <= 4'hf;
    // ready pins pass two sync flops before a select can see them
    repeat (3) @(posedge clk);
    for (int c = 7; c >= 0; c--) sel(3'(c), exp_sel(3'(c)), c > 4);
    sel(3'h1, 3'h1, 1'b0);
    pulse(3, 8'h01);
    pulse(3, 8'h03);
    chk({6'h00, pll_src}, 8'h01);
    count(256);
    chk(n0[7:0], 8'h02);
    chk(n1[7:0], 8'h10);
    chk(n2[7:0], 8'h40);
    repeat (4) begin
      d = 8'($random(seed));
      pulse(1, d);
      chk(slow_cal, d);
    end
    pulse(0, 8'h03);
    for (i = 0; i < 4 && rdy[2] !== 1'b0; i++) @(posedge clk);
    #1;
    chk({7'h00, rdy[2]}, 8'h00);
    sel(3'h2, 3'h1, 1'b1);
    pulse(3, 8'h00);
    chk({6'h00, pll_src}, 8'h00);
    sel(3'h0, 3'h0, 1'b0);
    finish_test;
  end
  // a hang ends the run as a failure
  initial begin
    #2_000_000;
    error_cnt++;
    finish_test;
  end
endmodule : iocc_top_tb
